// *** src/vk_defines.svh ***
// Constants of the video keyer datapath.
// Included by the package and the design modules; definitions only.
`ifndef VK_DEFINES_SVH
`define VK_DEFINES_SVH

// ----------------------------------------------------------------
// Video levels (10-bit, chroma offset binary)
// ----------------------------------------------------------------
`define VK_FULL 10'h3FF
`define VK_MID 10'h200
`define VK_BLACK 10'h000

// ----------------------------------------------------------------
// Key positioning delay line
// ----------------------------------------------------------------
`define VK_TAPS 12
`define VK_FILL_TAP 6

// ----------------------------------------------------------------
// Output buffer
// ----------------------------------------------------------------
`define VK_FIFO_W 30
`define VK_FIFO_DEPTH 16
`define VK_FIFO_AW 4
`define VK_READY_LEVEL 5'h0A

`endif

// *** src/vk_pkg.sv ***
// Types and shared arithmetic of the video keyer datapath.
// Assumes 10-bit video with luma black at zero, chroma centred at mid.
package vk_pkg;
`include "vk_defines.svh"

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [9:0] y;
      logic [9:0] cb;
      logic [9:0] cr;
   } vk_pix_t;

   typedef enum logic [2:0] {
      VK_ADDITIVE,
      VK_LUMINANCE,
      VK_LINEAR,
      VK_CHROMA,
      VK_PATTERN
   } vk_mode_t;

   typedef struct packed {
      vk_pix_t bg;
      vk_pix_t fill;
      logic [9:0] cut;
      logic [9:0] alt_cut;
      vk_pix_t mask;
      logic [9:0] wipe;
      logic [9:0] backing;
      logic [9:0] sec_backing;
   } vk_src_t;

   typedef struct packed {
      vk_mode_t mode;
      logic self_key;
      logic split;
      logic two_thresh;
      logic [9:0] clip;
      logic [9:0] gain;
      logic [9:0] clip_hi;
      logic [9:0] clip_lo;
      logic invert;
      logic inh_mask;
      logic force_mask;
      logic mask_wipe;
      logic [9:0] opacity;
      logic signed [2:0] key_pos;
      logic [1:0] key_size;
      logic coring;
      logic [9:0] core_level;
      logic show_key;
      logic reshape;
      logic [9:0] sup_y;
      logic [9:0] sup_c;
      logic [9:0] sec_y;
      logic [9:0] sec_c;
      logic flare_en;
      logic [9:0] flare_amt;
      vk_pix_t sup_color;
      logic shadow_en;
      logic [9:0] sh_offset;
      logic [1:0] sh_range;
      logic [9:0] sh_density;
   } vk_cfg_t;

   // ----------------------------------------------------------------
   // Arithmetic
   // ----------------------------------------------------------------
   // Fraction multiply; full scale acts as exactly one
   function automatic logic [9:0] vk_mul(input logic [9:0] a,
                                         input logic [9:0] b);
      logic [20:0] p;
      p = 21'(a) * 21'({1'b0, b} + {10'h000, b[9]});
      return p[19:10];
   endfunction

   function automatic logic [9:0] vk_sat(input logic signed [13:0] v);
      if (v < 14'sh0000)
         return `VK_BLACK;
      if (v > 14'sh03FF)
         return `VK_FULL;
      return v[9:0];
   endfunction

   function automatic logic [9:0] vk_blend(input logic [9:0] x,
                                           input logic [9:0] z,
                                           input logic [9:0] a);
      return vk_sat(14'(vk_mul(x, ~a)) + 14'(vk_mul(z, a)));
   endfunction

   function automatic vk_pix_t vk_blend_pix(input vk_pix_t x,
                                            input vk_pix_t z,
                                            input logic [9:0] a);
      vk_pix_t r;
      r.y = vk_blend(x.y, z.y, a);
      r.cb = vk_blend(x.cb, z.cb, a);
      r.cr = vk_blend(x.cr, z.cr, a);
      return r;
   endfunction

   function automatic vk_pix_t vk_black();
      vk_pix_t r;
      r.y = `VK_BLACK;
      r.cb = `VK_MID;
      r.cr = `VK_MID;
      return r;
   endfunction

   // Premultiply: black where a is zero, the pixel where a is full
   function automatic vk_pix_t vk_scale_pix(input vk_pix_t x,
                                            input logic [9:0] a);
      return vk_blend_pix(vk_black(), x, a);
   endfunction

endpackage

// *** src/vk_fifo.sv ***
// Output buffer of the keyer: flip-flop storage with a registered head.
// Assumes one clock; the filler watches o_level to hold off early.
`include "vk_defines.svh"
module vk_fifo #(
   parameter int W = `VK_FIFO_W,
   parameter int D = `VK_FIFO_DEPTH,
   parameter int AW = `VK_FIFO_AW
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Filling side
   input wire logic i_valid,
   input wire logic [W-1:0] i_data,
   output logic o_in_ready,
   output logic [AW:0] o_level,
   // Draining side
   output logic o_valid,
   output logic [W-1:0] o_data,
   input wire logic i_ready
);
   logic [W-1:0] mem_reg [D];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;

   assign o_in_ready = (cnt_reg != (AW+1)'(D));
   assign o_level = cnt_reg;
   assign push = i_valid && o_in_ready;
   assign pop = (cnt_reg != '0) && (!o_valid || i_ready);

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_reg[wr_reg] <= i_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push)
            wr_reg <= wr_reg + 1'b1;
         if (pop)
            rd_reg <= rd_reg + 1'b1;
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // Head register keeps the output straight from a flip-flop
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_valid <= 1'b0;
         o_data <= '0;
      end else if (pop) begin
         o_valid <= 1'b1;
         o_data <= mem_reg[rd_reg];
      end else if (i_ready) begin
         o_valid <= 1'b0;
      end
   end
endmodule

// *** src/vk_key_shaper.sv ***
// Turns a key cut level into a key control fraction: thresholds and
// optional S-shaped edges. One registered stage.
// Assumes the caller chooses bypass and S-shaping from the key mode.
`include "vk_defines.svh"
module vk_key_shaper
   import vk_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Controls
   input wire logic i_bypass,
   input wire logic i_s_shape,
   input wire logic i_two_thresh,
   input wire logic [9:0] i_clip,
   input wire logic [9:0] i_gain,
   input wire logic [9:0] i_clip_hi,
   input wire logic [9:0] i_clip_lo,
   // Cut in, control out
   input wire logic [9:0] i_cut,
   output logic [9:0] o_alpha
);
   logic signed [12:0] lo;
   logic signed [12:0] hi;
   logic signed [12:0] d;
   logic signed [12:0] span;
   logic [21:0] q;
   logic [9:0] lin;
   logic [19:0] x2;
   logic [19:0] x3;
   logic [12:0] s;
   logic [9:0] shaped;

   always_comb begin
      if (i_two_thresh) begin
         lo = 13'(i_clip_lo);
         hi = 13'(i_clip_hi);
      end else begin
         lo = 13'(i_clip) - 13'(i_gain >> 1);
         hi = 13'(i_clip) + 13'(i_gain >> 1);
      end
      d = 13'(i_cut) - lo;
      span = hi - lo;
      q = '0;
      if (span <= 13'sh0000)
         lin = (d >= 13'sh0000) ? `VK_FULL : `VK_BLACK;
      else if (d <= 13'sh0000)
         lin = `VK_BLACK;
      else if (d >= span)
         lin = `VK_FULL;
      else begin
         q = 22'(d[11:0]) * 22'(`VK_FULL) / 22'(span[11:0]);
         lin = q[9:0];
      end
   end

   // S-shaped edges
   // Smoothstep keeps both end points, so thresholds and gain hold
   always_comb begin
      x2 = 20'(lin) * 20'(lin);
      x3 = 20'(x2[19:10]) * 20'(lin);
      s = 13'(3 * 13'(x2[19:10])) - 13'(2 * 13'(x3[19:10]));
      shaped = (s > 13'h03FF) ? `VK_FULL : s[9:0];
   end

   always_ff @(posedge i_clk) begin
      if (i_rst)
         o_alpha <= `VK_BLACK;
      else if (i_bypass)
         o_alpha <= i_cut;
      else if (i_s_shape)
         o_alpha <= shaped;
      else
         o_alpha <= lin;
   end
endmodule

// *** src/vk_keyer.sv ***
// Per-pixel keyer: builds a key control signal from the selected cut,
// adjusts it, processes the fill and composites over background.
// Assumes all sources arrive aligned on one valid, and the drain side
// honours valid and ready on the output.

`include "vk_defines.svh"

module vk_keyer (
   // Clock and reset
   input wire logic I_SYS_CLK,
   input wire logic I_SYS_RST,
   // Operator settings
   input wire vk_pkg::vk_cfg_t I_CFG,
   // Source stream
   input wire logic I_IN_VALID,
   input wire vk_pkg::vk_src_t I_SRC,
   output logic O_IN_READY,
   // Program output stream
   output logic O_OUT_VALID,
   output vk_pkg::vk_pix_t O_OUT_PIX,
   input wire logic I_OUT_READY
);
   import vk_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam int TAPS = `VK_TAPS;
   localparam int FT = `VK_FILL_TAP;

   vk_src_t line_reg [TAPS];
   logic [9:0] cut_line_reg [TAPS];
   logic take;
   logic [9:0] cut_in;
   logic [9:0] cut_pos;
   logic v1_reg;
   vk_src_t s1_reg;
   logic [9:0] c1_reg;
   logic v2_reg;
   vk_src_t s2_reg;
   logic [9:0] alpha2;
   logic v3_reg;
   logic [9:0] a3_reg;
   vk_pix_t fg3_reg;
   vk_pix_t bg3_reg;
   logic [9:0] a3_next;
   vk_pix_t fg3_next;
   vk_pix_t bg3_next;
   logic v4_reg;
   vk_pix_t p4_reg;
   vk_pix_t p4_next;
   logic fifo_rdy;
   logic [`VK_FIFO_AW:0] fifo_lvl;
   logic [`VK_FIFO_W-1:0] fifo_out;
   logic is_chroma;
   logic additive;

   assign take = I_IN_VALID && O_IN_READY;
   assign is_chroma = (I_CFG.mode == VK_CHROMA);
   assign additive = (I_CFG.mode == VK_ADDITIVE)
                     || (is_chroma && !I_CFG.reshape);

   function automatic logic [9:0] vk_min(input logic [9:0] a,
                                         input logic [9:0] b);
      return (a < b) ? a : b;
   endfunction

   // Flare: take off a share of the suppression colour
   function automatic logic [9:0] vk_flare(input logic [9:0] c,
                                           input logic [9:0] col,
                                           input logic [9:0] amt);
      logic signed [21:0] p;
      p = (22'sd0 + 22'(signed'({1'b0, col}) - 11'sd512))
          * 22'(signed'({1'b0, amt}));
      return vk_sat(14'(signed'({1'b0, c})) - 14'(p >>> 10));
   endfunction

   // ----------------------------------------------------------------
   // Cut source selection
   // ----------------------------------------------------------------
   always_comb begin
      if (I_CFG.mode == VK_PATTERN)
         cut_in = I_SRC.wipe;
      else if (is_chroma)
         cut_in = ~I_SRC.backing;
      else if (I_CFG.split)
         cut_in = I_SRC.alt_cut;
      else if (I_CFG.self_key)
         cut_in = I_SRC.fill.y;
      else
         cut_in = I_SRC.cut;
   end

   // ----------------------------------------------------------------
   // Key positioning and size
   // ----------------------------------------------------------------
   // Line only moves on accepted pixels, so offsets are in pixels
   always_ff @(posedge I_SYS_CLK) begin
      if (take) begin
         line_reg[0] <= I_SRC;
         cut_line_reg[0] <= cut_in;
         for (int i = 1; i < TAPS; i++) begin
            line_reg[i] <= line_reg[i-1];
            cut_line_reg[i] <= cut_line_reg[i-1];
         end
      end
   end

   always_comb begin
      int ct;
      ct = FT - int'(I_CFG.key_pos);
      cut_pos = cut_line_reg[ct];
      for (int k = 1; k <= 2; k++) begin
         if (k <= int'(I_CFG.key_size)) begin
            cut_pos = vk_min(cut_pos, cut_line_reg[ct-k]);
            cut_pos = vk_min(cut_pos, cut_line_reg[ct+k]);
         end
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SYS_RST) begin
         v1_reg <= 1'b0;
         s1_reg <= '0;
         c1_reg <= `VK_BLACK;
      end else begin
         v1_reg <= take;
         s1_reg <= line_reg[FT];
         c1_reg <= cut_pos;
      end
   end

   // ----------------------------------------------------------------
   // Key control: thresholds and shaping
   // ----------------------------------------------------------------
   // shaping on luminance
   vk_key_shaper u_shaper (
      .i_clk(I_SYS_CLK),
      .i_rst(I_SYS_RST),
      .i_bypass(I_CFG.mode == VK_PATTERN),
      .i_s_shape(I_CFG.mode == VK_LUMINANCE),
      .i_two_thresh(I_CFG.two_thresh),
      .i_clip(I_CFG.clip),
      .i_gain(I_CFG.gain),
      .i_clip_hi(I_CFG.clip_hi),
      .i_clip_lo(I_CFG.clip_lo),
      .i_cut(c1_reg),
      .o_alpha(alpha2)
   );

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SYS_RST) begin
         v2_reg <= 1'b0;
         s2_reg <= '0;
      end else begin
         v2_reg <= v1_reg;
         s2_reg <= s1_reg;
      end
   end

   // ----------------------------------------------------------------
   // Key adjustment and fill processing
   // ----------------------------------------------------------------
   always_comb begin
      logic [9:0] m;
      logic [9:0] sh;
      vk_pix_t lvl;
      m = I_CFG.mask_wipe ? s2_reg.wipe : s2_reg.mask.y;
      sh = `VK_BLACK;
      lvl = vk_black();
      a3_next = alpha2;
      if (I_CFG.invert)
         a3_next = ~a3_next;
      if (I_CFG.inh_mask)
         a3_next = vk_mul(a3_next, ~m);
      if (I_CFG.force_mask)
         a3_next = a3_next + vk_mul(~a3_next, m);
      a3_next = vk_mul(a3_next, I_CFG.opacity);

      fg3_next = s2_reg.fill;
      bg3_next = s2_reg.bg;
      if (is_chroma) begin
         lvl.y = I_CFG.sup_y;
         lvl.cb = I_CFG.sup_c;
         lvl.cr = I_CFG.sup_c;
         fg3_next = vk_blend_pix(fg3_next, lvl, s2_reg.backing);
         lvl.y = I_CFG.sec_y;
         lvl.cb = I_CFG.sec_c;
         lvl.cr = I_CFG.sec_c;
         fg3_next = vk_blend_pix(fg3_next, lvl, s2_reg.sec_backing);
         if (I_CFG.flare_en) begin
            fg3_next.y = vk_sat(14'(fg3_next.y)
               - 14'(vk_mul(I_CFG.sup_color.y, I_CFG.flare_amt)));
            fg3_next.cb = vk_flare(fg3_next.cb, I_CFG.sup_color.cb,
                                   I_CFG.flare_amt);
            fg3_next.cr = vk_flare(fg3_next.cr, I_CFG.sup_color.cr,
                                   I_CFG.flare_amt);
         end
         // shadow onto background
         // Shadow is darkness below the offset, only on backing
         if (I_CFG.shadow_en) begin
            sh = vk_sat((14'(I_CFG.sh_offset) - 14'(s2_reg.fill.y))
                        <<< I_CFG.sh_range);
            sh = vk_mul(vk_mul(sh, s2_reg.backing), I_CFG.sh_density);
            bg3_next = vk_blend_pix(bg3_next, vk_black(), sh);
         end
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SYS_RST) begin
         v3_reg <= 1'b0;
         a3_reg <= `VK_BLACK;
         fg3_reg <= '0;
         bg3_reg <= '0;
      end else begin
         v3_reg <= v2_reg;
         a3_reg <= a3_next;
         fg3_reg <= fg3_next;
         bg3_reg <= bg3_next;
      end
   end

   // ----------------------------------------------------------------
   // Composite
   // ----------------------------------------------------------------
   always_comb begin
      vk_pix_t fk;
      vk_pix_t bh;
      fk = additive ? fg3_reg : vk_scale_pix(fg3_reg, a3_reg);
      if (I_CFG.coring && (a3_reg == `VK_BLACK)
          && (fk.y < I_CFG.core_level))
         fk = vk_black();
      bh = vk_scale_pix(bg3_reg, ~a3_reg);
      p4_next.y = vk_sat(14'(bh.y) + 14'(fk.y));
      p4_next.cb = vk_sat(14'(bh.cb) + 14'(fk.cb) - 14'(`VK_MID));
      p4_next.cr = vk_sat(14'(bh.cr) + 14'(fk.cr) - 14'(`VK_MID));
      if (I_CFG.show_key) begin
         p4_next.y = a3_reg;
         p4_next.cb = `VK_MID;
         p4_next.cr = `VK_MID;
      end
   end

   always_ff @(posedge I_SYS_CLK) begin
      if (I_SYS_RST) begin
         v4_reg <= 1'b0;
         p4_reg <= '0;
      end else begin
         v4_reg <= v3_reg;
         p4_reg <= p4_next;
      end
   end

   // ----------------------------------------------------------------
   // Output buffer and back-pressure
   // ----------------------------------------------------------------
   // Pipeline never stalls: ready drops early enough that all pixels
   // in flight still fit in the buffer
   always_ff @(posedge I_SYS_CLK) begin
      if (I_SYS_RST)
         O_IN_READY <= 1'b0;
      else
         O_IN_READY <= fifo_rdy && (fifo_lvl <= `VK_READY_LEVEL);
   end

   vk_fifo #(
      .W(`VK_FIFO_W),
      .D(`VK_FIFO_DEPTH),
      .AW(`VK_FIFO_AW)
   ) u_fifo (
      .i_clk(I_SYS_CLK),
      .i_rst(I_SYS_RST),
      .i_valid(v4_reg),
      .i_data(p4_reg),
      .o_in_ready(fifo_rdy),
      .o_level(fifo_lvl),
      .o_valid(O_OUT_VALID),
      .o_data(fifo_out),
      .i_ready(I_OUT_READY)
   );

   assign O_OUT_PIX = fifo_out;
endmodule

// *** bench/vk_chk.sv ***
// Port-level checks of the keyer, bound to its top module.
// Assumes settings and mask video stay put while pixels are pending.
module vk_chk (
   // Clock and reset
   input wire logic I_SYS_CLK,
   input wire logic I_SYS_RST,
   // Settings and source stream
   input wire vk_pkg::vk_cfg_t I_CFG,
   input wire logic I_IN_VALID,
   input wire vk_pkg::vk_src_t I_SRC,
   input wire logic O_IN_READY,
   // Program output stream
   input wire logic O_OUT_VALID,
   input wire vk_pkg::vk_pix_t O_OUT_PIX,
   input wire logic I_OUT_READY
);
   timeunit 1ns;
   timeprecision 100ps;
   import vk_pkg::*;
   logic [15:0] acc_reg;
   logic [15:0] take_reg;

   default clocking @(posedge I_SYS_CLK);
   endclocking
   default disable iff (I_SYS_RST);

   // Wrapping counts; the run is far shorter than the wrap
   always_ff @(posedge I_SYS_CLK) begin
      if (I_SYS_RST)
         acc_reg <= 16'h0000;
      else if (I_IN_VALID && O_IN_READY)
         acc_reg <= acc_reg + 16'h0001;
   end
   always_ff @(posedge I_SYS_CLK) begin
      if (I_SYS_RST)
         take_reg <= 16'h0000;
      else if (O_OUT_VALID && I_OUT_READY)
         take_reg <= take_reg + 16'h0001;
   end

   rst_quiet_a: assert property ($fell(I_SYS_RST) |->
      !O_IN_READY && !O_OUT_VALID && O_OUT_PIX == '0)
      else $error("outputs active right after reset");
   out_hold_a: assert property (O_OUT_VALID && !I_OUT_READY |=>
      O_OUT_VALID && $stable(O_OUT_PIX))
      else $error("output pixel changed before taken");
   show_grey_a: assert property (O_OUT_VALID && I_CFG.show_key |->
      O_OUT_PIX.cb == 10'h200 && O_OUT_PIX.cr == 10'h200)
      else $error("show key output not monochrome");
   opac_zero_a: assert property (O_OUT_VALID && I_CFG.show_key &&
      I_CFG.opacity == 10'h000 |-> O_OUT_PIX.y == 10'h000)
      else $error("zero opacity left a key");
   force_full_a: assert property (O_OUT_VALID && I_CFG.show_key &&
      I_CFG.force_mask && !I_CFG.mask_wipe && I_SRC.mask.y == 10'h3FF &&
      I_CFG.opacity == 10'h3FF |-> O_OUT_PIX.y == 10'h3FF)
      else $error("force mask did not key");
   inhibit_zero_a: assert property (O_OUT_VALID && I_CFG.show_key &&
      I_CFG.inh_mask && !I_CFG.force_mask && !I_CFG.mask_wipe &&
      I_SRC.mask.y == 10'h3FF |-> O_OUT_PIX.y == 10'h000)
      else $error("inhibit mask let a key through");
   no_extra_a: assert property (O_OUT_VALID |-> take_reg < acc_reg)
      else $error("output pixel without a source pixel");
   fill_bound_a: assert property ((acc_reg - take_reg) <= 16'h0018)
      else $error("more pixels held than the buffer allows");
   first_out_a: assert property (acc_reg == take_reg &&
      I_IN_VALID && O_IN_READY |-> ##[1:10] O_OUT_VALID)
      else $error("accepted pixel never came out");

   cover property (O_OUT_VALID && !I_OUT_READY);
   cover property (I_IN_VALID && !O_IN_READY);
   cover property (O_OUT_VALID && I_CFG.show_key && I_CFG.mode == VK_PATTERN);
endmodule

bind vk_keyer vk_chk u_chk (.I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST),
   .I_CFG(I_CFG), .I_IN_VALID(I_IN_VALID), .I_SRC(I_SRC),
   .O_IN_READY(O_IN_READY), .O_OUT_VALID(O_OUT_VALID),
   .O_OUT_PIX(O_OUT_PIX), .I_OUT_READY(I_OUT_READY));

// *** bench/vk_sink.sv ***
// Model of the program output bus that drains the keyer.
// Assumes the bench asks for a stall while it fills the buffer.
module vk_sink (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Stall request
   input wire logic i_stall,
   // Ready to the keyer
   output logic o_ready
);
   timeunit 1ns;
   timeprecision 100ps;
   // Random stalls keep the output hold path busy
   always_ff @(posedge i_clk) begin
      if (i_rst || i_stall)
         o_ready <= 1'b0;
      else
         o_ready <= ($urandom_range(3) != 0);
   end
endmodule

// *** bench/testbench.sv ***
// Self-checking bench of the keyer: random settings and pixels.
// Assumes vk_pkg, the keyer, its checker and the sink model.
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import vk_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   vk_cfg_t cfg = '0;
   logic in_valid = 1'b0;
   vk_src_t src = '0;
   logic stall = 1'b0;
   logic saw_full = 1'b0;
   logic in_ready, out_valid, out_ready;
   vk_pix_t out_pix;
   vk_src_t src_q[$];
   int mismatches = 0, comparisons = 0, nout = 0, base = 0;

   vk_keyer u_dut (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_CFG(cfg),
      .I_IN_VALID(in_valid), .I_SRC(src), .O_IN_READY(in_ready),
      .O_OUT_VALID(out_valid), .O_OUT_PIX(out_pix),
      .I_OUT_READY(out_ready));
   vk_sink u_sink (.i_clk(clk), .i_rst(rst), .i_stall(stall),
      .o_ready(out_ready));

   initial begin
      forever #5 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Expectations
   // ----------------------------------------------------------------
   function automatic logic [9:0] mul(input logic [9:0] a, b);
      logic [20:0] p;
      p = 21'(a) * 21'({1'b0, b} + {10'h000, b[9]});
      return p[19:10];
   endfunction

   function automatic logic [9:0] near(input logic [9:0] c);
      case ($urandom_range(2))
         0: return c;
         1: return c - 10'h001;
         default: return 10'($urandom);
      endcase
   endfunction

   // Cut level that the selected mode takes from one source pixel
   function automatic logic [9:0] cut_of(input vk_src_t t);
      if (cfg.mode == VK_PATTERN)
         return t.wipe;
      if (cfg.mode == VK_CHROMA)
         return ~t.backing;
      return cfg.split ? t.alt_cut : cfg.self_key ? t.fill.y : t.cut;
   endfunction

   // Hard key (gain 0) keeps alpha at the ends, where rounding is exact
   function automatic vk_pix_t want(input int n);
      vk_src_t s;
      logic [9:0] a, m, f;
      int y, c, j;
      // Fill sits seven accepted pixels behind the output
      s = src_q[n - 7];
      c = n - 7 + int'($signed(cfg.key_pos));
      f = cut_of(src_q[c]);
      // Size narrows the cut: lowest level within size pixels, two at most
      for (j = 1; j <= 2 && j <= int'(cfg.key_size); j++) begin
         if (cut_of(src_q[c - j]) < f)
            f = cut_of(src_q[c - j]);
         if (cut_of(src_q[c + j]) < f)
            f = cut_of(src_q[c + j]);
      end
      a = (f >= cfg.clip) ? 10'h3FF : 10'h000;
      if (cfg.mode == VK_PATTERN)
         a = f;
      m = cfg.mask_wipe ? s.wipe : s.mask.y;
      if (cfg.invert)
         a = ~a;
      if (cfg.inh_mask)
         a = mul(a, ~m);
      if (cfg.force_mask)
         a = a + mul(~a, m);
      a = mul(a, cfg.opacity);
      f = s.fill.y;
      if (cfg.coring && a == 10'h000 && f < cfg.core_level)
         f = 10'h000;
      y = int'(mul(s.bg.y, ~a));
      y = y + int'((cfg.mode == VK_ADDITIVE) ? f : mul(f, a));
      if (cfg.show_key)
         return {a, 10'h200, 10'h200};
      return {(y > 32'h3FF) ? 10'h3FF : 10'(y), 20'h00000};
   endfunction

   task automatic check(input vk_pix_t got, exp, input logic all);
      comparisons++;
      if (all ? got !== exp : got.y !== exp.y) begin
         mismatches++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic push(input vk_src_t s);
      int w;
      w = 0;
      src_q.push_back(s);
      src <= s;
      in_valid <= 1'b1;
      @(posedge clk);
      while (!in_ready) begin
         w++;
         if (w == 30)
            stall <= 1'b0;
         @(posedge clk);
      end
   endtask

   task automatic end_sim();
      $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Early outputs of a run mix in pixels of the previous settings
   always @(posedge clk) begin
      if (!rst && in_valid && !in_ready)
         saw_full <= 1'b1;
      if (!rst && out_valid && out_ready) begin
         if (nout >= base + 12)
            check(out_pix, want(nout), cfg.show_key);
         nout++;
      end
   end

   initial begin
      repeat (10000) @(posedge clk);
      mismatches++;
      end_sim();
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      vk_mode_t modes[5];
      logic [9:0] ops[3];
      logic [9:0] wv;
      vk_cfg_t c;
      vk_src_t s;
      int k, i;
      modes = '{VK_ADDITIVE, VK_LUMINANCE, VK_LINEAR, VK_PATTERN, VK_CHROMA};
      ops = '{10'h000, 10'h200, 10'h3FF};
      void'($urandom(32'h83D9A6B5));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      for (k = 0; k < 24; k++) begin
         c = '0;
         c.mode = modes[k % 5];
         c.clip = 10'($urandom_range(32'h3FE, 1));
         c.key_pos = 3'($urandom_range(6) + 5);
         c.key_size = 2'($urandom);
         c.invert = 1'($urandom);
         // Chroma fill has no model here; its key is seen in show key
         c.show_key = (c.mode == VK_CHROMA) || 1'($urandom);
         c.coring = 1'($urandom);
         c.core_level = 10'($urandom);
         c.opacity = c.show_key ? ops[$urandom_range(2)] : 10'h3FF;
         if (c.mode != VK_PATTERN) begin
            c.split = 1'($urandom);
            c.self_key = 1'($urandom);
            c.inh_mask = 1'($urandom);
            c.force_mask = 1'($urandom);
            c.mask_wipe = 1'($urandom);
         end
         wv = $urandom_range(1) ? 10'h3FF : 10'h000;
         stall <= (k == 5);
         base = src_q.size();
         cfg <= c;
         for (i = 0; i < 24; i++) begin
            s.bg = 30'($urandom);
            s.fill = 30'($urandom);
            s.cut = near(c.clip);
            s.alt_cut = near(c.clip);
            s.mask = {10'h3FF, 20'($urandom)};
            s.wipe = (c.mode == VK_PATTERN) ? 10'($urandom) : wv;
            s.backing = 10'($urandom);
            s.sec_backing = 10'($urandom);
            push(s);
         end
         in_valid <= 1'b0;
         i = 0;
         while (nout < src_q.size() && i < 400) begin
            @(posedge clk);
            i++;
         end
         @(posedge clk);
         comparisons++;
         if (out_valid !== 1'b0 || i == 400
             || (k == 5 && saw_full !== 1'b1)) begin
            mismatches++;
            $display("Error at %0t: got %h want %h", $time, out_valid, 0);
         end
      end
      end_sim();
   end
endmodule
